// ---- rtl/cgm_consts.svh ----
`ifndef CGM_CONSTS_SVH
`define CGM_CONSTS_SVH
// register word addresses on the avalon slave
`define CGM_ADDR_CTRL_ONE    3'h0
`define CGM_ADDR_CTRL_TWO    3'h1
`define CGM_ADDR_CTRL_THREE  3'h2
`define CGM_ADDR_CTRL_FOUR   3'h3
`define CGM_ADDR_STATUS      3'h4
// reset values
`define CGM_RST_CTRL_ONE     8'h04
`define CGM_RST_CTRL_TWO     8'h40
`define CGM_RST_CTRL_THREE   8'h01
`define CGM_RST_CTRL_FOUR    8'h00
`define CGM_RST_REF_DIV      13'h0001
`define CGM_RST_PLL_MULT     6'h04
// gen_ctrl_one fields
`define CGM_C1_CLOCK_SOURCE_SEL          7:6
`define CGM_C1_REF_DIVIDER          5:3
`define CGM_C1_INT_REF_SELECT         2
// gen_ctrl_two fields
`define CGM_C2_BUS_DIVIDER          7:6
`define CGM_C2_RANGE         5
`define CGM_C2_HGO           4
`define CGM_C2_LP            3
`define CGM_C2_EXT_REF_IS_OSC         2
`define CGM_C2_EXT_REF_CLK_EN       1
// gen_ctrl_three fields
`define CGM_C3_PLL_SELECT          6
`define CGM_C3_REF_DIV_EXTEND         4
`define CGM_C3_PLL_MULTIPLIER          3:0
// gen_ctrl_four fields
`define CGM_C4_BOOST         5
`define CGM_C4_DRS           1:0
// gen_status_reg fields
`define CGM_ST_LOCK          6
`define CGM_ST_PLL_SELECT_STATUS         5
`define CGM_ST_IREFST        4
`define CGM_ST_CLOCK_SOURCE_STATUS         3:2
`define CGM_ST_OSCRDY        1
// source codes
`define CGM_SRC_LOOP         2'h0
`define CGM_SRC_INT          2'h1
`define CGM_SRC_EXT          2'h2
`define CGM_SRC_PLL          2'h3
// fll factors
`define CGM_FLL_F0           11'h200
`define CGM_FLL_F1           11'h400
`define CGM_FLL_F2           11'h600
`define CGM_FLL_B0           11'h260
`define CGM_FLL_B1           11'h4C0
`define CGM_FLL_B2           11'h720
// extended divider shift (divide by 32) and pll step (4 per code)
`define CGM_REF_DIV_EXTEND_SHIFT      5
`define CGM_PLL_MULTIPLIER_SHIFT       2
`endif

// ---- rtl/cgm_pkg.sv ----
package cgm_pkg;
  // one-hot clock modes
  typedef enum logic [7:0] {
    CGM_FLL_INT_ENGAGED     = 8'h01,
    CGM_FLL_EXT_ENGAGED     = 8'h02,
    CGM_FLL_EXT_BYPASS      = 8'h04,
    CGM_FLL_INT_BYPASS      = 8'h08,
    CGM_PLL_EXT_ENGAGED     = 8'h10,
    CGM_PLL_EXT_BYPASS      = 8'h20,
    CGM_LOWPOWER_INT_BYPASS = 8'h40,
    CGM_LOWPOWER_EXT_BYPASS = 8'h80
  } cgm_mode_t;
  // one-hot source switch states
  typedef enum logic [2:0] {
    CGM_SW_RUN   = 3'h1,
    CGM_SW_DRAIN = 3'h2,
    CGM_SW_ARM   = 3'h4
  } cgm_sw_t;
endpackage

// ---- rtl/cgm_tick_div.sv ----
`timescale 1ns/10ps
`default_nettype none
module cgm_tick_div (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tick,
  input  wire logic [1:0] i_log2_div,
  output logic            o_tick
);
  import cgm_pkg::*;
  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } cgm_div_t;
  cgm_div_t st_reg;
  cgm_div_t st_next;
  logic [2:0] limit;
  // ---------------------------------------------------------------
  // divide incoming ticks by 1, 2, 4 or 8
  // ---------------------------------------------------------------
  always_comb begin
    limit   = 3'((4'h1 << i_log2_div) - 4'h1);
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (i_tick) begin
      if (st_reg.cnt >= limit) begin
        st_next.cnt  = 3'h0;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 3'h1;
      end
    end
  end
  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_tick = st_reg.tick;
endmodule
`default_nettype wire

// ---- rtl/cgm_mode_ctrl.sv ----
//
// Overview of operation
// - boost clear: range code 0,1,2 gives fll factor 512, 1024, 1536
// - boost set: range code 0,1,2 gives fll factor 608, 1216, 1824
// - writes to fll range ignored while low-power bypass or pll select set
// - in the four fll modes the fll factor may change while low power and pll select are clear
// - status bits follow pll, reference, source and oscillator selects; software polls
// - bus clock is generator output divided by two in every mode
// - internal fll engaged: internal reference times factor over bus divider
// - external fll engaged: divided reference times factor; reference 31.25 to 39.0625 khz
// - external pll engaged: divided reference times multiplier; reference 1 to 2 mhz
// - bypass modes output selected reference divided by bus divider
// - control one: source 7:6, ref divider 5:3, internal ref select bit 2
// - control two: bus divider, range, gain, low power, osc select, ext enable
// - status: lock 6, pll status 5, ref status 4, source 3:2, osc ready 1
// - control three: pll select 6, divider extension 4, multiplier 3:0
// - high range with extension: ref code 3 divides 256 in fll, 8 in pll
// - divider extension has no effect in pll modes
// - low-power external bypass keeps pll off; clearing low power enters pll bypass
// - reset starts internal fll engaged with bus divider two
//
`timescale 1ns/10ps
`default_nettype none
`include "cgm_consts.svh"
module cgm_mode_ctrl (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [2:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic              i_int_ref_tick,
  input  wire logic              i_ext_ref_tick,
  input  wire logic              i_fll_tick,
  input  wire logic              i_pll_tick,
  input  wire logic              i_loop_lock,
  input  wire logic              i_osc_ready,
  output cgm_pkg::cgm_mode_t     o_mode,
  output logic      [10:0]       o_fll_factor,
  output logic      [12:0]       o_ref_div,
  output logic      [5:0]        o_pll_multiplier,
  output logic                   o_high_gain_osc,
  output logic                   o_ext_ref_clk_en,
  output logic                   o_pll_enable,
  output logic                   o_gen_clock_out,
  output logic                   o_bus_clk_tick
);
  import cgm_pkg::*;
  typedef struct packed {
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    logic [7:0]  ctrl_three;
    logic [7:0]  ctrl_four;
    logic [1:0]  act_src;
    logic        pll_select_status;
    logic        irefst;
    cgm_sw_t     sw;
    logic [1:0]  lock_sync;
    logic [1:0]  osc_sync;
    logic        wait_q;
    logic [31:0] rdata;
    cgm_mode_t   mode;
    logic [10:0] fll_factor;
    logic [12:0] ref_div;
    logic [5:0]  pll_mult;
    logic        pll_en;
  } cgm_state_t;

  cgm_state_t st_reg;
  cgm_state_t st_next;
  logic       req_src;
  logic [1:0] want_src;
  logic       sel_tick;
  logic       gen_tick;
  logic [7:0] status;
  logic       take;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // tick of a given source
  function automatic logic src_tick(input logic [1:0] src, input logic [3:0] ticks);
    src_tick = ticks[src];
  endfunction

  // mode from control fields
  function automatic cgm_mode_t decode_mode(input logic [7:0] c1, input logic [7:0] c2,
                                            input logic [7:0] c3);
    decode_mode = CGM_FLL_INT_ENGAGED;
    if (c1[`CGM_C1_CLOCK_SOURCE_SEL] == `CGM_SRC_LOOP) begin
      if (c3[`CGM_C3_PLL_SELECT]) begin
        decode_mode = CGM_PLL_EXT_ENGAGED;
      end else if (c1[`CGM_C1_INT_REF_SELECT]) begin
        decode_mode = CGM_FLL_INT_ENGAGED;
      end else begin
        decode_mode = CGM_FLL_EXT_ENGAGED;
      end
    end else if (c1[`CGM_C1_CLOCK_SOURCE_SEL] == `CGM_SRC_INT) begin
      decode_mode = c2[`CGM_C2_LP] ? CGM_LOWPOWER_INT_BYPASS : CGM_FLL_INT_BYPASS;
    end else if (c2[`CGM_C2_LP]) begin
      decode_mode = CGM_LOWPOWER_EXT_BYPASS;
    end else begin
      decode_mode = c3[`CGM_C3_PLL_SELECT] ? CGM_PLL_EXT_BYPASS : CGM_FLL_EXT_BYPASS;
    end
  endfunction

  // ---------------------------------------------------------------
  // source request and status word
  // ---------------------------------------------------------------
  always_comb begin
    if (st_reg.ctrl_one[`CGM_C1_CLOCK_SOURCE_SEL] == `CGM_SRC_LOOP) begin
      want_src = st_reg.pll_select_status ? `CGM_SRC_PLL : `CGM_SRC_LOOP;
    end else begin
      want_src = st_reg.ctrl_one[`CGM_C1_CLOCK_SOURCE_SEL];
    end
    req_src = (want_src != st_reg.act_src);
    status  = 8'h00;
    status[`CGM_ST_LOCK]   = st_reg.lock_sync[1];
    status[`CGM_ST_PLL_SELECT_STATUS]  = st_reg.pll_select_status;
    status[`CGM_ST_IREFST] = st_reg.irefst;
    status[`CGM_ST_CLOCK_SOURCE_STATUS]  = st_reg.act_src;
    status[`CGM_ST_OSCRDY] = st_reg.osc_sync[1] & st_reg.ctrl_two[`CGM_C2_EXT_REF_IS_OSC];
    take     = (i_avs_read | i_avs_write) & ~st_reg.wait_q;
    sel_tick = (st_reg.sw == CGM_SW_RUN) &
               src_tick(st_reg.act_src, {i_pll_tick, i_ext_ref_tick, i_int_ref_tick, i_fll_tick});
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // avalon slave: one wait cycle, then the access completes
    st_next.wait_q = ~((i_avs_read | i_avs_write) & st_reg.wait_q);
    if ((i_avs_read | i_avs_write) & st_reg.wait_q) begin
      case (i_avs_address)
        `CGM_ADDR_CTRL_ONE:   st_next.rdata = {24'h000000, st_reg.ctrl_one};
        `CGM_ADDR_CTRL_TWO:   st_next.rdata = {24'h000000, st_reg.ctrl_two};
        `CGM_ADDR_CTRL_THREE: st_next.rdata = {24'h000000, st_reg.ctrl_three};
        `CGM_ADDR_CTRL_FOUR:  st_next.rdata = {24'h000000, st_reg.ctrl_four};
        `CGM_ADDR_STATUS:     st_next.rdata = {24'h000000, status};
        default:              st_next.rdata = 32'h00000000;
      endcase
    end
    if (take & i_avs_write & i_avs_byteenable[0]) begin
      case (i_avs_address)
        `CGM_ADDR_CTRL_ONE: begin
          st_next.ctrl_one = i_avs_writedata[7:0];
        end
        `CGM_ADDR_CTRL_TWO: begin
          st_next.ctrl_two = {i_avs_writedata[7:1], 1'b0};
        end
        `CGM_ADDR_CTRL_THREE: begin
          st_next.ctrl_three = {1'b0, i_avs_writedata[6], 1'b0, i_avs_writedata[4:0]};
        end
        `CGM_ADDR_CTRL_FOUR: begin
          st_next.ctrl_four[`CGM_C4_BOOST] = i_avs_writedata[`CGM_C4_BOOST];
          if (!st_reg.ctrl_two[`CGM_C2_LP] && !st_reg.ctrl_three[`CGM_C3_PLL_SELECT]) begin
            st_next.ctrl_four[`CGM_C4_DRS] = i_avs_writedata[`CGM_C4_DRS];
          end
        end
        default: begin
        end
      endcase
    end
    // pin level inputs pass two flops
    st_next.lock_sync = {st_reg.lock_sync[0], i_loop_lock};
    st_next.osc_sync  = {st_reg.osc_sync[0], i_osc_ready};
    // pll stays off in low power; select is only prepared there
    st_next.pll_en = st_reg.ctrl_three[`CGM_C3_PLL_SELECT] & ~st_reg.ctrl_two[`CGM_C2_LP];
    if (!st_reg.ctrl_two[`CGM_C2_LP]) begin
      st_next.pll_select_status = st_reg.ctrl_three[`CGM_C3_PLL_SELECT];
    end
    st_next.irefst = st_reg.ctrl_one[`CGM_C1_INT_REF_SELECT];
    st_next.mode   = decode_mode(st_reg.ctrl_one, st_reg.ctrl_two, st_reg.ctrl_three);
    // fll factor table
    case ({st_reg.ctrl_four[`CGM_C4_BOOST], st_reg.ctrl_four[`CGM_C4_DRS]})
      3'h0:    st_next.fll_factor = `CGM_FLL_F0;
      3'h1:    st_next.fll_factor = `CGM_FLL_F1;
      3'h2:    st_next.fll_factor = `CGM_FLL_F2;
      3'h4:    st_next.fll_factor = `CGM_FLL_B0;
      3'h5:    st_next.fll_factor = `CGM_FLL_B1;
      3'h6:    st_next.fll_factor = `CGM_FLL_B2;
      default: st_next.fll_factor = st_reg.fll_factor;
    endcase
    // reference divider: extension only in fll with high range
    st_next.ref_div = 13'(13'h0001 << st_reg.ctrl_one[`CGM_C1_REF_DIVIDER]);
    if (!st_reg.ctrl_three[`CGM_C3_PLL_SELECT] && st_reg.ctrl_two[`CGM_C2_RANGE] &&
        st_reg.ctrl_three[`CGM_C3_REF_DIV_EXTEND]) begin
      st_next.ref_div = 13'(st_next.ref_div << `CGM_REF_DIV_EXTEND_SHIFT);
    end
    st_next.pll_mult = 6'({2'h0, st_reg.ctrl_three[`CGM_C3_PLL_MULTIPLIER]} << `CGM_PLL_MULTIPLIER_SHIFT);
    // glitch-free source switch: stop on old edge, restart on new edge
    case (st_reg.sw)
      CGM_SW_RUN: begin
        if (req_src) begin
          st_next.sw = CGM_SW_DRAIN;
        end
      end
      CGM_SW_DRAIN: begin
        if (src_tick(st_reg.act_src, {i_pll_tick, i_ext_ref_tick, i_int_ref_tick, i_fll_tick})) begin
          st_next.sw = CGM_SW_ARM;
        end
      end
      CGM_SW_ARM: begin
        if (src_tick(want_src, {i_pll_tick, i_ext_ref_tick, i_int_ref_tick, i_fll_tick})) begin
          st_next.act_src = want_src;
          st_next.sw      = CGM_SW_RUN;
        end
      end
      default: begin
        st_next.sw = CGM_SW_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg            <= '0;
      st_reg.ctrl_one   <= `CGM_RST_CTRL_ONE;
      st_reg.ctrl_two   <= `CGM_RST_CTRL_TWO;
      st_reg.ctrl_three <= `CGM_RST_CTRL_THREE;
      st_reg.ctrl_four  <= `CGM_RST_CTRL_FOUR;
      st_reg.act_src    <= `CGM_SRC_LOOP;
      st_reg.irefst     <= 1'b1;
      st_reg.sw         <= CGM_SW_RUN;
      st_reg.wait_q     <= 1'b1;
      st_reg.mode       <= CGM_FLL_INT_ENGAGED;
      st_reg.fll_factor <= `CGM_FLL_F0;
      st_reg.ref_div    <= `CGM_RST_REF_DIV;
      st_reg.pll_mult   <= `CGM_RST_PLL_MULT;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // output dividers: bus divider, then fixed divide by two
  // ---------------------------------------------------------------
  cgm_tick_div u_gen_div (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_tick     (sel_tick),
    .i_log2_div (st_reg.ctrl_two[`CGM_C2_BUS_DIVIDER]),
    .o_tick     (gen_tick)
  );
  cgm_tick_div u_bus_div (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_tick     (gen_tick),
    .i_log2_div (2'h1),
    .o_tick     (o_bus_clk_tick)
  );

  // outputs from flops
  assign o_gen_clock_out   = gen_tick;
  assign o_avs_readdata    = st_reg.rdata;
  assign o_avs_waitrequest = st_reg.wait_q;
  assign o_mode            = st_reg.mode;
  assign o_fll_factor      = st_reg.fll_factor;
  assign o_ref_div         = st_reg.ref_div;
  assign o_pll_multiplier  = st_reg.pll_mult;
  assign o_high_gain_osc   = st_reg.ctrl_two[`CGM_C2_HGO];
  assign o_ext_ref_clk_en  = st_reg.ctrl_two[`CGM_C2_EXT_REF_CLK_EN];
  assign o_pll_enable      = st_reg.pll_en;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_RANGE_WRITE_IGNORED: assert property (@(posedge i_clk) disable iff (i_rst)
    (take && i_avs_write && i_avs_address == `CGM_ADDR_CTRL_FOUR &&
     (st_reg.ctrl_two[`CGM_C2_LP] || st_reg.ctrl_three[`CGM_C3_PLL_SELECT]))
    |=> $stable(st_reg.ctrl_four[`CGM_C4_DRS]))
    else $error("range write not ignored");
  AST_FACTOR_MID: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg.ctrl_four[5:0] == 6'h01)[*2] |-> o_fll_factor == 11'h400)
    else $error("fll factor not 1024");
  AST_FACTOR_BOOST_HIGH: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg.ctrl_four[5:0] == 6'h22)[*2] |-> o_fll_factor == 11'h720)
    else $error("boosted fll factor not 1824");
  AST_REF_DIV_FLL: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg.ctrl_one[5:3] == 3'h3 && st_reg.ctrl_two[5] && st_reg.ctrl_three[6:4] == 3'h1)[*2]
    |-> o_ref_div == 13'h0100)
    else $error("ref divider not 256");
  AST_REF_DIV_PLL: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg.ctrl_one[5:3] == 3'h3 && st_reg.ctrl_three[6])[*2] |-> o_ref_div == 13'h0008)
    else $error("ref divider not 8 in pll");
  AST_PLL_SELECT_STATUS_HELD_IN_LP: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.ctrl_two[3] |=> $stable(st_reg.pll_select_status))
    else $error("pll status moved in low power");
  AST_SRC_CHANGE_AFTER_ARM: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(st_reg.act_src) |-> $past(st_reg.sw) == CGM_SW_ARM)
    else $error("source status changed outside switch");
  AST_NO_TICK_WHILE_SWITCH: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.sw != CGM_SW_RUN |=> !gen_tick)
    else $error("tick passed during switch");
  AST_BUS_HALF: assert property (@(posedge i_clk) disable iff (i_rst)
    o_bus_clk_tick |-> ##1 !o_bus_clk_tick ##0 $past(gen_tick, 2))
    else $error("bus tick not from generator tick");
  AST_RESET_STATE: assert property (@(posedge i_clk)
    $past(i_rst) |-> st_reg.ctrl_two[7:6] == 2'h1 && st_reg.ctrl_one == 8'h04)
    else $error("reset state not internal fll engaged");
  AST_WAIT_ONE_CYCLE: assert property (@(posedge i_clk) disable iff (i_rst)
    ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("bus answer late");
  AST_FACTOR_LOW: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg.ctrl_four[5:0] == 6'h00)[*2] |-> o_fll_factor == 11'h200)
    else $error("fll factor not 512");
  AST_MULT_32: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg.ctrl_three[`CGM_C3_PLL_MULTIPLIER] == 4'h8)[*2] |-> o_pll_multiplier == 6'h20)
    else $error("pll multiplier not 32");
  AST_MODE_PLL_ENGAGED: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg.ctrl_one[`CGM_C1_CLOCK_SOURCE_SEL] == `CGM_SRC_LOOP && st_reg.ctrl_three[`CGM_C3_PLL_SELECT])[*2]
    |-> o_mode == CGM_PLL_EXT_ENGAGED)
    else $error("mode not pll engaged");
  AST_PLL_OFF_IN_LP: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.ctrl_two[`CGM_C2_LP] |=> !o_pll_enable)
    else $error("pll enabled in low power");
  AST_PLL_SELECT_STATUS_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_rst)
    !st_reg.ctrl_two[`CGM_C2_LP] |=> st_reg.pll_select_status == $past(st_reg.ctrl_three[`CGM_C3_PLL_SELECT]))
    else $error("pll status not following select");
  AST_IREFST_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.irefst == $past(st_reg.ctrl_one[`CGM_C1_INT_REF_SELECT]))
    else $error("reference status not following select");
  COV_PLL_SWITCH: cover property (@(posedge i_clk) disable iff (i_rst)
    st_reg.sw == CGM_SW_ARM ##1 st_reg.act_src == 2'h3);
  COV_EXT_SWITCH: cover property (@(posedge i_clk) disable iff (i_rst)
    $changed(st_reg.act_src) && st_reg.act_src == 2'h2);
  COV_RANGE_IGNORED: cover property (@(posedge i_clk) disable iff (i_rst)
    take && i_avs_write && i_avs_address == `CGM_ADDR_CTRL_FOUR && st_reg.ctrl_three[6]);
  COV_LP_EXIT_PLL: cover property (@(posedge i_clk) disable iff (i_rst)
    $fell(st_reg.ctrl_two[`CGM_C2_LP]) && st_reg.ctrl_three[`CGM_C3_PLL_SELECT]);
endmodule
`default_nettype wire

// ---- tb/cgm_mode_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cgm_consts.svh"
module cgm_mode_ctrl_tb;
  import cgm_pkg::*;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic              i_clk;
  logic              i_rst;
  logic [2:0]        addr;
  logic              rd;
  logic              wr;
  logic [31:0]       wdata;
  logic [3:0]        be;
  logic [31:0]       rdata;
  logic              wait_req;
  logic              int_t = 1'b0;
  logic              ext_t = 1'b0;
  logic              fll_t = 1'b0;
  logic              pll_t = 1'b0;
  logic              lock;
  logic              osc;
  cgm_mode_t         mode;
  logic [10:0]       fll_f;
  logic [12:0]       ref_divider;
  logic [5:0]        mult;
  logic              high_gain_osc;
  logic              erclk;
  logic              pll_en;
  logic              gen;
  logic              bus_t;
  logic [7:0]        tcnt = 8'h00;
  logic [7:0]        q;
  int                num_errors;
  int                samples_checked;
  logic [10:0]       fac [6] = '{11'd512, 11'd1024, 11'd1536, 11'd608, 11'd1216, 11'd1824};
  logic [7:0]        rst_val [5] = '{8'h04, 8'h40, 8'h01, 8'h00, 8'h10};

  cgm_mode_ctrl dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_int_ref_tick(int_t), .i_ext_ref_tick(ext_t),
    .i_fll_tick(fll_t), .i_pll_tick(pll_t), .i_loop_lock(lock), .i_osc_ready(osc),
    .o_mode(mode), .o_fll_factor(fll_f), .o_ref_div(ref_divider), .o_pll_multiplier(mult),
    .o_high_gain_osc(high_gain_osc), .o_ext_ref_clk_en(erclk), .o_pll_enable(pll_en),
    .o_gen_clock_out(gen), .o_bus_clk_tick(bus_t)
  );

  // clock and free running source ticks at different rates
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    tcnt  <= tcnt + 8'h01;
    int_t <= (tcnt[2:0] == 3'h0);
    ext_t <= (tcnt[1:0] == 2'h1);
    fll_t <= tcnt[0];
    pll_t <= (tcnt[1:0] != 2'h3);
  end

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic results;
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // counts may differ by a pulse or two at the window edges
  task automatic chk_near(input string nm, input int e, input int g);
    samples_checked++;
    if (g > e + 2 || g + 2 < e) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // one avalon access: hold until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [3:0] e);
    int n;
    @(posedge i_clk);
    addr  <= a;
    wdata <= {24'h0, d};
    be    <= e;
    wr    <= w;
    rd    <= ~w;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    if (wait_req !== 1'b0) begin
      num_errors++;
      results();
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, 4'hF);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask

  // poll status until the masked field matches, bounded
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do begin
      xfer(1'b0, `CGM_ADDR_STATUS, 8'h00, 4'hF);
      n++;
    end while ((q & m) !== v && n < 200);
    chk("status_poll", {24'h0, v}, {24'h0, q & m});
    if ((q & m) !== v)
      results();
  endtask

  task automatic settle;
    repeat (4) @(posedge i_clk);
  endtask

  // count generator, bus and source pulses over a window
  task automatic measure(input int src, input int dv);
    int ng, nb, ns;
    ng = 0;
    nb = 0;
    ns = 0;
    repeat (240) begin
      @(posedge i_clk);
      ng += (gen === 1'b1);
      nb += (bus_t === 1'b1);
      ns += (src == 0) ? (fll_t === 1'b1) : (src == 1) ? (ext_t === 1'b1) :
            (src == 2) ? (pll_t === 1'b1) : (int_t === 1'b1);
    end
    chk_near("gen_rate", ns / dv, ng);
    chk_near("bus_rate", ng / 2, nb);
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    num_errors = 0;
    samples_checked = 0;
    {lock, osc, rd, wr} = 4'h0;
    addr = 3'h0;
    wdata = 32'h0;
    be = 4'hF;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset state and register reset values
    chk("mode", {24'h0, CGM_FLL_INT_ENGAGED}, {24'h0, mode});
    chk("fll_factor", 32'd512, {21'h0, fll_f});
    for (int i = 0; i < 5; i++)
      rchk("reg_reset", i[2:0], rst_val[i]);
    measure(0, 2);
    // refused accesses
    rchk("unmapped", 3'h5, 8'h00);
    wreg(`CGM_ADDR_STATUS, 8'hFF);
    rchk("status_ro", `CGM_ADDR_STATUS, 8'h10);
    xfer(1'b1, `CGM_ADDR_CTRL_FOUR, 8'h02, 4'h0);
    settle();
    chk("fll_factor", 32'd512, {21'h0, fll_f});
    // internal bypass, low-power internal bypass and back to internal fll engaged
    wreg(`CGM_ADDR_CTRL_ONE, 8'h44);
    poll(8'h0C, 8'h04);
    settle();
    chk("mode", {24'h0, CGM_FLL_INT_BYPASS}, {24'h0, mode});
    measure(3, 2);
    wreg(`CGM_ADDR_CTRL_TWO, 8'h48);
    settle();
    chk("mode", {24'h0, CGM_LOWPOWER_INT_BYPASS}, {24'h0, mode});
    wreg(`CGM_ADDR_CTRL_TWO, 8'h40);
    wreg(`CGM_ADDR_CTRL_ONE, 8'h04);
    poll(8'h0C, 8'h00);
    // internal fll engaged to external fll bypass
    wreg(`CGM_ADDR_CTRL_TWO, 8'h36);
    osc <= 1'b1;
    poll(8'h02, 8'h02);
    chk("osc_ctrl", 32'h3, {30'h0, high_gain_osc, erclk});
    wreg(`CGM_ADDR_CTRL_THREE, 8'h10);
    wreg(`CGM_ADDR_CTRL_ONE, 8'h18);
    poll(8'h10, 8'h00);
    settle();
    chk("mode", {24'h0, CGM_FLL_EXT_ENGAGED}, {24'h0, mode});
    wreg(`CGM_ADDR_CTRL_ONE, 8'h98);
    poll(8'h1C, 8'h08);
    settle();
    chk("mode", {24'h0, CGM_FLL_EXT_BYPASS}, {24'h0, mode});
    chk("ref_div", 32'd256, {19'h0, ref_divider});
    measure(1, 1);
    wreg(`CGM_ADDR_CTRL_FOUR, 8'h01);
    settle();
    chk("fll_factor", 32'd1024, {21'h0, fll_f});
    // range codes 0, 1 and 2 with boost clear and set, outside internal modes
    for (int b = 0; b < 2; b++)
      for (int c = 0; c < 3; c++) begin
        wreg(`CGM_ADDR_CTRL_FOUR, {2'h0, b[0], 3'h0, c[1:0]});
        settle();
        chk("fll_factor", {21'h0, fac[b * 3 + c]}, {21'h0, fll_f});
      end
    wreg(`CGM_ADDR_CTRL_FOUR, 8'h00);
    // through low-power external bypass to pll bypass
    wreg(`CGM_ADDR_CTRL_TWO, 8'h3E);
    settle();
    chk("mode", {24'h0, CGM_LOWPOWER_EXT_BYPASS}, {24'h0, mode});
    wreg(`CGM_ADDR_CTRL_FOUR, 8'h02);
    settle();
    chk("fll_factor", 32'd512, {21'h0, fll_f});
    wreg(`CGM_ADDR_CTRL_THREE, 8'h58);
    settle();
    chk("pll_off", {24'h0, CGM_LOWPOWER_EXT_BYPASS}, {23'h0, pll_en, mode});
    chk("pll_mult", 32'd32, {26'h0, mult});
    wreg(`CGM_ADDR_CTRL_TWO, 8'h36);
    lock <= 1'b1;
    poll(8'h20, 8'h20);
    settle();
    chk("mode", {24'h0, CGM_PLL_EXT_BYPASS}, {24'h0, mode});
    chk("ref_div", 32'd8, {19'h0, ref_divider});
    chk("pll_en", 32'h1, {31'h0, pll_en});
    wreg(`CGM_ADDR_CTRL_FOUR, 8'h02);
    settle();
    chk("fll_factor", 32'd512, {21'h0, fll_f});
    // pll bypass to pll engaged
    wreg(`CGM_ADDR_CTRL_ONE, 8'h18);
    poll(8'h0C, 8'h0C);
    settle();
    chk("mode", {24'h0, CGM_PLL_EXT_ENGAGED}, {24'h0, mode});
    measure(2, 1);
    results();
  end
endmodule
`default_nettype wire
